//--- rtl/actu_fifo.sv
// staging fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module actu_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    // =====================================
    // status
    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid && !full && !flush;
    assign pop = out_ready && !empty && !flush;

    // =====================================
    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // =====================================
    // pointers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule : actu_fifo

`default_nettype wire

//--- rtl/actu_top.sv
// address compare and trace unit with its register port
`timescale 1ns/1ps
`default_nettype none
`include "actu_regs.svh"

module actu_top
    import actu_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic mcu_secure,
    input wire logic [3:0] trig_mode,
    input wire logic begin_trace,
    input wire logic trigger_qualify_type,
    input wire logic cpu_valid,
    input wire logic cpu_fetch,
    input wire logic cpu_rw,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_data,
    output logic break_req,
    output logic break_is_tag,
    output logic capture_active_flag,
    output logic [3:0] valid_count,
    output logic sample_dropped
);
    // =====================================
    // register state
    logic [7:0] compare_a_high;
    logic [7:0] compare_a_low;
    logic [7:0] compare_b_high;
    logic [7:0] compare_b_low;
    logic unit_enable;
    logic armed;
    logic tag_select;
    logic break_request_enable;
    logic cmp_a_dir_value;
    logic cmp_a_dir_qualify;
    logic cmp_b_dir_value;
    logic cmp_b_dir_qualify;

    // =====================================
    // trace ring and run state
    logic [`ACTU_WORD_W-1:0] ring [`ACTU_TRACE_DEPTH];
    logic [2:0] head;
    logic [3:0] cnt;
    logic [15:0] last_fetch;
    logic seen_a;
    actu_state_t state;

    // =====================================
    // decoded strobes
    logic wr_cmp_ok;
    logic wr_ctrl;
    logic rd_lo;
    logic prof_read;
    logic next_enable;
    logic arm_start;
    logic arm_stop;

    // =====================================
    // comparator and trigger terms
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic dir_a_ok;
    logic dir_b_ok;
    logic exec_ok;
    logic match_a;
    logic match_b;
    logic in_range;
    logic trig;
    logic event_mode;
    logic begin_eff;
    logic end_done;
    logic begin_done;
    logic run_done;

    // =====================================
    // staging path
    logic store_evt;
    logic [`ACTU_WORD_W-1:0] store_word;
    logic stage_ready;
    logic stage_valid;
    logic [`ACTU_WORD_W-1:0] stage_word;
    logic ring_ready;
    logic drain;
    logic [`ACTU_WORD_W-1:0] head_word;

    // =====================================
    // register port decode
    assign wr_cmp_ok = reg_wr && !armed;
    assign wr_ctrl = reg_wr && (reg_addr == `ACTU_OFF_CONTROL);
    assign rd_lo = reg_rd && (reg_addr == `ACTU_OFF_TRACE_LO);
    assign prof_read = rd_lo && !armed;

    // set only when not secure, clear always
    assign next_enable = reg_wdata[`ACTU_CTRL_ENABLE] && (unit_enable || !mcu_secure);
    assign arm_start = wr_ctrl && next_enable && reg_wdata[`ACTU_CTRL_ARM];
    assign arm_stop = wr_ctrl && (!next_enable || !reg_wdata[`ACTU_CTRL_ARM]);

    // =====================================
    // comparators
    assign cmp_a = {compare_a_high, compare_a_low};
    assign cmp_b = {compare_b_high, compare_b_low};
    assign dir_a_ok = !cmp_a_dir_qualify || (cpu_rw == cmp_a_dir_value);
    assign dir_b_ok = !cmp_b_dir_qualify || (cpu_rw == cmp_b_dir_value);
    // tag qualification approximated by matching only on opcode fetches
    assign exec_ok = !trigger_qualify_type || cpu_fetch;
    assign match_a = cpu_valid && exec_ok && dir_a_ok && (cpu_addr == cmp_a);
    assign match_b = cpu_valid && exec_ok && dir_b_ok && (cpu_addr == cmp_b);
    assign in_range = (cpu_addr >= cmp_a) && (cpu_addr <= cmp_b);

    // =====================================
    // trigger selection
    always_comb begin
        trig = 1'b0;
        case (trig_mode)
            ACTU_TRG_A_ONLY: begin
                trig = match_a;
            end
            ACTU_TRG_A_OR_B: begin
                trig = match_a || match_b;
            end
            ACTU_TRG_A_THEN_B: begin
                trig = match_b && seen_a;
            end
            ACTU_TRG_EVENT_B: begin
                trig = match_b;
            end
            ACTU_TRG_A_THEN_EVENT_B: begin
                trig = match_b && seen_a;
            end
            ACTU_TRG_A_AND_BDATA: begin
                trig = match_a && (cpu_data == compare_b_low);
            end
            ACTU_TRG_A_NOT_BDATA: begin
                trig = match_a && (cpu_data != compare_b_low);
            end
            ACTU_TRG_INSIDE: begin
                trig = cpu_valid && exec_ok && dir_a_ok && in_range;
            end
            ACTU_TRG_OUTSIDE: begin
                trig = cpu_valid && exec_ok && dir_a_ok && !in_range;
            end
            default: begin
                trig = 1'b0;
            end
        endcase
    end

    assign event_mode = (trig_mode == ACTU_TRG_EVENT_B) || (trig_mode == ACTU_TRG_A_THEN_EVENT_B);
    // event-only runs are always begin traces
    assign begin_eff = begin_trace || event_mode;

    // =====================================
    // run completion
    assign end_done = armed && !begin_eff && trig;
    assign begin_done = armed && begin_eff && drain && (cnt == `ACTU_TRACE_LAST);
    assign run_done = end_done || begin_done;

    // =====================================
    // what gets stored
    always_comb begin
        store_evt = 1'b0;
        if (armed) begin
            if (event_mode) begin
                store_evt = trig;
            end else if (state == ACTU_ST_STORE) begin
                store_evt = cpu_valid && cpu_fetch;
            end else if (state == ACTU_ST_HUNT) begin
                store_evt = cpu_valid && cpu_fetch && trig;
            end
        end
    end

    assign store_word = event_mode ? {`ACTU_ZERO_BYTE, cpu_data} : cpu_addr;

    // a profiling read owns the ring for its cycle, so the stage waits
    assign ring_ready = !prof_read && !(begin_eff && (cnt == `ACTU_TRACE_FULL));
    assign drain = stage_valid && ring_ready;

    actu_fifo #(
        .WIDTH(`ACTU_WORD_W),
        .DEPTH(`ACTU_STAGE_DEPTH)
    ) u_stage (
        .clk(clk),
        .arst_n(arst_n),
        .flush(arm_start),
        .in_valid(store_evt),
        .in_ready(stage_ready),
        .in_data(store_word),
        .out_valid(stage_valid),
        .out_ready(ring_ready),
        .out_data(stage_word),
        .full(),
        .empty()
    );

    // =====================================
    // comparator registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            compare_a_high <= `ACTU_CMP_RST;
            compare_a_low <= `ACTU_CMP_RST;
            compare_b_high <= `ACTU_CMP_RST;
            compare_b_low <= `ACTU_CMP_RST;
        end else if (wr_cmp_ok) begin
            case (reg_addr)
                `ACTU_OFF_CMP_A_HI: begin
                    compare_a_high <= reg_wdata;
                end
                `ACTU_OFF_CMP_A_LO: begin
                    compare_a_low <= reg_wdata;
                end
                `ACTU_OFF_CMP_B_HI: begin
                    compare_b_high <= reg_wdata;
                end
                `ACTU_OFF_CMP_B_LO: begin
                    compare_b_low <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // =====================================
    // control register fields
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            unit_enable <= 1'(`ACTU_CTRL_RST >> `ACTU_CTRL_ENABLE);
            tag_select <= 1'b0;
            break_request_enable <= 1'b0;
            cmp_a_dir_value <= 1'b0;
            cmp_a_dir_qualify <= 1'b0;
            cmp_b_dir_value <= 1'b0;
            cmp_b_dir_qualify <= 1'b0;
        end else if (wr_ctrl) begin
            unit_enable <= next_enable;
            tag_select <= reg_wdata[`ACTU_CTRL_TAG];
            break_request_enable <= reg_wdata[`ACTU_CTRL_BRK];
            cmp_a_dir_value <= reg_wdata[`ACTU_CTRL_A_VAL];
            cmp_a_dir_qualify <= reg_wdata[`ACTU_CTRL_A_QUAL];
            cmp_b_dir_value <= reg_wdata[`ACTU_CTRL_B_VAL];
            cmp_b_dir_qualify <= reg_wdata[`ACTU_CTRL_B_QUAL];
        end
    end

    // =====================================
    // arm bit, which doubles as the armed flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed <= 1'b0;
        end else if (arm_start) begin
            armed <= 1'b1;
        end else if (arm_stop || run_done) begin
            armed <= 1'b0;
        end
    end

    assign capture_active_flag = armed;

    // =====================================
    // run state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ACTU_ST_IDLE;
        end else begin
            case (state)
                ACTU_ST_IDLE: begin
                    if (arm_start) begin
                        state <= (begin_eff && !event_mode) ? ACTU_ST_HUNT : ACTU_ST_STORE;
                    end
                end
                ACTU_ST_HUNT: begin
                    if (arm_stop || !armed) begin
                        state <= ACTU_ST_IDLE;
                    end else if (trig) begin
                        state <= ACTU_ST_STORE;
                    end
                end
                ACTU_ST_STORE: begin
                    if (arm_stop || run_done || !armed) begin
                        state <= ACTU_ST_IDLE;
                    end
                end
                default: begin
                    state <= ACTU_ST_IDLE;
                end
            endcase
        end
    end

    // =====================================
    // sequence memory for the a-then-b modes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_a <= 1'b0;
        end else if (arm_start) begin
            seen_a <= 1'b0;
        end else if (armed && match_a) begin
            seen_a <= 1'b1;
        end
    end

    // =====================================
    // opcode address for profiling
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_fetch <= 16'h0000;
        end else if (cpu_valid && cpu_fetch) begin
            last_fetch <= cpu_addr;
        end
    end

    // =====================================
    // trace ring: head is the word shown, and the slot it leaves is the last
    always_ff @(posedge clk) begin
        if (prof_read) begin
            ring[head] <= last_fetch;
        end else if (drain) begin
            ring[head] <= stage_word;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            head <= 3'h0;
        end else if (prof_read || drain) begin
            head <= head + 3'h1;
        end
    end

    // valid count stops at eight and is cleared only by arming; stage words still drain into it after the run, reads do not lower it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 4'h0;
        end else if (arm_start) begin
            cnt <= 4'h0;
        end else if (drain && (cnt != `ACTU_TRACE_FULL)) begin
            cnt <= cnt + 4'h1;
        end
    end

    assign valid_count = cnt;

    // =====================================
    // break requests
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            break_req <= 1'b0;
            break_is_tag <= 1'b0;
        end else begin
            break_req <= break_request_enable && run_done;
            break_is_tag <= tag_select;
        end
    end

    // refused store, the stage was full
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_dropped <= 1'b0;
        end else begin
            sample_dropped <= store_evt && !stage_ready;
        end
    end

    // =====================================
    // read data
    assign head_word = ring[head];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ACTU_OFF_CMP_A_HI: begin
                    reg_rdata <= compare_a_high;
                end
                `ACTU_OFF_CMP_A_LO: begin
                    reg_rdata <= compare_a_low;
                end
                `ACTU_OFF_CMP_B_HI: begin
                    reg_rdata <= compare_b_high;
                end
                `ACTU_OFF_CMP_B_LO: begin
                    reg_rdata <= compare_b_low;
                end
                `ACTU_OFF_TRACE_HI: begin
                    reg_rdata <= event_mode ? `ACTU_ZERO_BYTE : head_word[15:8];
                end
                `ACTU_OFF_TRACE_LO: begin
                    reg_rdata <= head_word[7:0];
                end
                `ACTU_OFF_CONTROL: begin
                    reg_rdata <= {unit_enable, armed, tag_select, break_request_enable,
                        cmp_a_dir_value, cmp_a_dir_qualify, cmp_b_dir_value, cmp_b_dir_qualify};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end

endmodule : actu_top

`default_nettype wire

//--- shared/actu_pkg.sv
// types shared by the trace unit modules
package actu_pkg;

    // =====================================
    // trigger mode codes
    typedef enum logic [3:0] {
        ACTU_TRG_A_ONLY = 4'b0000,
        ACTU_TRG_A_OR_B = 4'b0001,
        ACTU_TRG_A_THEN_B = 4'b0010,
        ACTU_TRG_EVENT_B = 4'b0011,
        ACTU_TRG_A_THEN_EVENT_B = 4'b0100,
        ACTU_TRG_A_AND_BDATA = 4'b0101,
        ACTU_TRG_A_NOT_BDATA = 4'b0110,
        ACTU_TRG_INSIDE = 4'b0111,
        ACTU_TRG_OUTSIDE = 4'b1000
    } actu_mode_t;

    // =====================================
    // capture run states
    typedef enum logic [1:0] {
        ACTU_ST_IDLE = 2'b00,
        ACTU_ST_HUNT = 2'b01,
        ACTU_ST_STORE = 2'b10
    } actu_state_t;

endpackage : actu_pkg

//--- shared/actu_regs.svh
// register offsets, field positions and reset values of the trace unit
`ifndef ACTU_REGS_SVH
`define ACTU_REGS_SVH

// =====================================
// register offsets on the register port
`define ACTU_OFF_CMP_A_HI 4'h0
`define ACTU_OFF_CMP_A_LO 4'h1
`define ACTU_OFF_CMP_B_HI 4'h2
`define ACTU_OFF_CMP_B_LO 4'h3
`define ACTU_OFF_TRACE_HI 4'h4
`define ACTU_OFF_TRACE_LO 4'h5
`define ACTU_OFF_CONTROL 4'h6

// =====================================
// debug_control field positions
`define ACTU_CTRL_ENABLE 7
`define ACTU_CTRL_ARM 6
`define ACTU_CTRL_TAG 5
`define ACTU_CTRL_BRK 4
`define ACTU_CTRL_A_VAL 3
`define ACTU_CTRL_A_QUAL 2
`define ACTU_CTRL_B_VAL 1
`define ACTU_CTRL_B_QUAL 0

// =====================================
// reset values and sizes
`define ACTU_CMP_RST 8'h00
`define ACTU_CTRL_RST 8'h00
`define ACTU_ZERO_BYTE 8'h00
`define ACTU_TRACE_DEPTH 8
`define ACTU_TRACE_FULL 4'h8
`define ACTU_TRACE_LAST 4'h7
`define ACTU_STAGE_DEPTH 4
`define ACTU_WORD_W 16

`endif

//--- verif/actu_cpu_model.sv
// cpu bus model: one access per call, bus scrambled when idle
`timescale 1ns/1ps
`default_nettype none

module actu_cpu_model (
    input wire logic clk,
    input wire logic break_req,
    output logic cpu_valid,
    output logic cpu_fetch,
    output logic cpu_rw,
    output logic [15:0] cpu_addr,
    output logic [7:0] cpu_data
);
    initial begin
        cpu_valid = 1'b0;
        cpu_fetch = 1'b0;
        cpu_rw = 1'b1;
        cpu_addr = 16'h0000;
        cpu_data = 8'h00;
    end

    // ==========
    // one bus cycle, break sampled after its edge
    task automatic access(input logic [15:0] a, input logic rw, input logic f, output logic brk);
        @(posedge clk);
        #2;
        cpu_valid = 1'b1;
        cpu_fetch = f;
        cpu_rw = rw;
        cpu_addr = a;
        cpu_data = a[7:0] ^ 8'h5a;
        @(posedge clk);
        #2;
        brk = break_req;
        cpu_valid = 1'b0;
        cpu_fetch = 1'b0;
        // idle bus must not look like a repeat of the access
        cpu_addr = ~a;
        cpu_data = ~cpu_data;
    endtask : access
endmodule : actu_cpu_model

`default_nettype wire

//--- verif/actu_top_bench.sv
// self-checking bench for the trace unit
`timescale 1ns/1ps
`default_nettype none

module actu_top_bench
    import actu_pkg::*;
();
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic mcu_secure = 1'b0;
    logic [3:0] trig_mode = 4'h0;
    logic begin_trace = 1'b0;
    logic trigger_qualify_type = 1'b0;
    logic cpu_valid, cpu_fetch, cpu_rw;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_data;
    logic break_req, break_is_tag, capture_active_flag, sample_dropped;
    logic [3:0] valid_count;
    int failures = 0;
    int n_tests = 0;
    int seed = 77206;
    int cycles = 0;
    int drops = 0;
    logic brk;
    logic [7:0] rd, hi;
    logic [15:0] ca, cb, a, e, last;
    logic [15:0] exp_q[$];

    always #12.5 clk = ~clk;

    actu_top i_dut (.clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .mcu_secure,
        .trig_mode, .begin_trace, .trigger_qualify_type, .cpu_valid, .cpu_fetch, .cpu_rw, .cpu_addr,
        .cpu_data, .break_req, .break_is_tag, .capture_active_flag, .valid_count, .sample_dropped);
    actu_cpu_model i_cpu (.clk, .break_req, .cpu_valid, .cpu_fetch, .cpu_rw, .cpu_addr, .cpu_data);

    // ==========
    // helpers
    task automatic close_out();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        #2;
        reg_addr = ad;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #2;
        reg_wr = 1'b0;
    endtask : wr

    task automatic rdr(input logic [3:0] ad, output logic [7:0] d);
        @(posedge clk);
        #2;
        reg_addr = ad;
        reg_rd = 1'b1;
        @(posedge clk);
        #2;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rdr

    // hang guard, far above the few hundred cycles used
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end

    // registered pulse, looked at mid-cycle; an unknown counts as a drop
    always @(negedge clk) begin
        if (arst_n && sample_dropped !== 1'b0) begin
            drops++;
        end
    end

    // ==========
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        #2;
        arst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i != 4 && i != 5) begin
                rdr(4'(i), rd);
                chk("reset or unmapped", 16'h0000, rd);
            end
        end
        ca = 16'($random(seed));
        cb = ~ca;
        wr(4'h0, ca[15:8]);
        wr(4'h1, ca[7:0]);
        wr(4'h2, cb[15:8]);
        wr(4'h3, cb[7:0]);
        for (int i = 0; i < 4; i++) begin
            e = i < 2 ? ca : cb;
            rdr(4'(i), rd);
            chk("compare byte", i % 2 ? e[7:0] : e[15:8], rd);
        end
        mcu_secure = 1'b1;
        wr(4'h6, 8'h80);
        rdr(4'h6, rd);
        chk("enable while secure", 16'h0000, rd[7]);
        mcu_secure = 1'b0;
        // end trace, every direction setting on both comparators
        for (int s = 0; s < 2; s++) begin
            for (int q = 0; q < 4; q++) begin
                trig_mode = s ? 4'h1 : 4'h0;
                a = s ? cb : ca;
                e = 16'h00d0 | 16'(s << 5) | 16'(q << (s ? 0 : 2));
                wr(4'h6, e[7:0]);
                rdr(4'h6, rd);
                chk("control", e, rd);
                wr(4'h0, 8'hff);
                i_cpu.access(a, 1'b1, 1'b0, brk);
                chk("break on read", q != 1, brk);
                if (q == 1) begin
                    i_cpu.access(a, 1'b0, 1'b0, brk);
                    chk("break on write", 16'h0001, brk);
                end
                chk("armed after trigger", 16'h0000, capture_active_flag);
                chk("break type", 16'(s), break_is_tag);
                rdr(4'h0, rd);
                chk("locked compare", ca[15:8], rd);
            end
        end
        wr(4'h6, 8'hd0);
        wr(4'h6, 8'h90);
        i_cpu.access(ca, 1'b1, 1'b0, brk);
        chk("break after stop", 16'h0000, brk | capture_active_flag);
        wr(4'h6, 8'hc0);
        i_cpu.access(ca, 1'b1, 1'b0, brk);
        chk("break while gated", 16'h0000, brk | capture_active_flag);
        // begin trace: trigger fetch then seven more fill the trace
        begin_trace = 1'b1;
        trig_mode = 4'h0;
        wr(4'h6, 8'hd0);
        for (int i = 0; i < 8; i++) begin
            a = i ? 16'($random(seed)) : ca;
            i_cpu.access(a, 1'b1, 1'b1, brk);
            exp_q.push_back(a);
        end
        last = a;
        brk = 1'b0;
        // no trace reads until the run is over
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            #2;
            brk |= break_req;
        end
        chk("break at full", 16'h0001, brk);
        chk("run over", 16'h0000, capture_active_flag);
        chk("valid count", 16'h0008, valid_count);
        wr(4'h4, 8'hff);
        wr(4'h5, 8'hff);
        // sixteen reads: eight run words, then the profile of the first eight
        for (int k = 0; k < 16; k++) begin
            if (k % 3 == 1) begin
                last = 16'($random(seed));
                i_cpu.access(last, 1'b1, 1'b1, brk);
            end
            e = exp_q.pop_front();
            rdr(4'h4, hi);
            rdr(4'h5, rd);
            chk("trace high", e[15:8], hi);
            chk("trace low", e[7:0], rd);
            exp_q.push_back(last);
        end
        // event-only b, fetch qualified: only fetch cycles store a data byte
        trig_mode = ACTU_TRG_EVENT_B;
        trigger_qualify_type = 1'b1;
        wr(4'h6, 8'hd0);
        for (int i = 0; i < 16; i++) begin
            i_cpu.access(cb, 1'b1, 1'(i % 2), brk);
            if (i == 13) begin
                chk("event run armed", 16'h0001, capture_active_flag);
            end
        end
        @(posedge clk);
        #2;
        chk("event break at full", 16'h0001, break_req);
        chk("event count", 16'h0008, valid_count);
        for (int k = 0; k < 8; k++) begin
            rdr(4'h4, hi);
            rdr(4'h5, rd);
            chk("event mode high", 16'h0000, hi);
            chk("event data", 16'(cb[7:0] ^ 8'h5a), rd);
        end
        chk("dropped samples", 16'h0000, 16'(drops));
        close_out();
    end
endmodule : actu_top_bench

`default_nettype wire

//--- verif/actu_top_sva.sv
// port assertions for the trace unit
`timescale 1ns/1ps
`default_nettype none

module actu_top_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic mcu_secure,
    input wire logic [3:0] trig_mode,
    input wire logic break_req,
    input wire logic break_is_tag,
    input wire logic capture_active_flag,
    input wire logic [3:0] valid_count
);
    logic ctl_wr;
    assign ctl_wr = reg_wr && reg_addr == 4'h6;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ==========
    // control and run
    brk_type_a: assert property (ctl_wr |-> ##2 break_is_tag == $past(reg_wdata[5], 2))
        else $error("break type does not follow control");
    arm_start_a: assert property (ctl_wr && reg_wdata[7:6] == 2'b11 && !mcu_secure |=> capture_active_flag && valid_count == 4'h0)
        else $error("arm write did not start a run");
    run_stop_a: assert property (ctl_wr && !(reg_wdata[7] && reg_wdata[6]) |=> !capture_active_flag)
        else $error("run survived a stop write");
    brk_end_a: assert property (break_req |-> !capture_active_flag)
        else $error("break while still armed");
    brk_pulse_a: assert property (break_req |=> !break_req)
        else $error("break request longer than one cycle");
    count_max_a: assert property (valid_count <= 4'h8)
        else $error("valid count above eight");

    // ==========
    // register reads
    unmapped_zero_a: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    event_high_a: assert property (reg_rd && reg_addr == 4'h4 && trig_mode inside {4'h3, 4'h4} |=> reg_rdata == 8'h00)
        else $error("trace high not zero in event mode");

    arm_c: cover property (ctl_wr && reg_wdata[6]);
    brk_c: cover property (break_req);
    low_rd_c: cover property (reg_rd && reg_addr == 4'h5);
endmodule : actu_top_sva

bind actu_top actu_top_sva i_sva (.clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .mcu_secure, .trig_mode, .break_req, .break_is_tag, .capture_active_flag, .valid_count);

`default_nettype wire
